// ===== design/sdze_pkg.sv
package sdze_pkg;

    // zone indices for the delayed zones
    localparam int ZONE_FIRST_DELAYED = 2;
    localparam int ZONE_LAST          = 4;
    localparam int NUM_DELAYED_ZONES  = 3;

    // timer settings are counted in milliseconds
    localparam int        CLK_MHZ         = 200;
    localparam int        TICK_NS         = 1000000;
    localparam int        CLK_PERIOD_NS   = 1000 / CLK_MHZ;
    localparam int        TICK_CYCLES_INT = TICK_NS / CLK_PERIOD_NS;
    localparam logic [17:0] TICK_CYCLES   = 18'(TICK_CYCLES_INT);
    localparam int        TIMER_W         = 16;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;

    // first-zone ground element selection
    localparam logic Z1G_MHO       = 1'b0;
    localparam logic Z1G_REACTANCE = 1'b1;

    // second-zone ground mode selection
    typedef enum logic [1:0] {
        SDZE_Z2G_DISTANCE = 2'b00,
        SDZE_Z2G_DIROC    = 2'b01,
        SDZE_Z2G_BOTH     = 2'b10
    } sdze_z2g_mode_type;

    // fourth-zone direction
    localparam logic Z4_FORWARD = 1'b0;
    localparam logic Z4_REVERSE = 1'b1;

    // reach-reset flag states
    typedef enum logic [1:0] {
        SDZE_RR_IDLE    = 2'b00,
        SDZE_RR_SET     = 2'b01,
        SDZE_RR_LOCKOUT = 2'b10
    } sdze_rr_state_type;

endpackage

// ===== design/sdze_timer.sv
`timescale 1ns/1ps
`default_nettype none
// pickup / dropout delay on one level; a zero setting passes the input straight
module sdze_timer
    import sdze_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               tick_i,
    input  wire logic               in_i,
    input  wire logic [TIMER_W-1:0] pickup_i,
    input  wire logic [TIMER_W-1:0] dropout_i,
    output logic                    out_o
);
    logic [TIMER_W-1:0] cnt_q;
    logic               held_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= TIMER_ZERO;
            held_q <= 1'b0;
        end else if (in_i != held_q) begin
            if ((held_q ? dropout_i : pickup_i) == TIMER_ZERO) begin
                // follow at once; a stale level here would let the output re-arm early
                held_q <= in_i;
                cnt_q  <= TIMER_ZERO;
            end else if (tick_i) begin
                if ((held_q ? dropout_i : pickup_i) <= cnt_q + 16'h0001) begin
                    held_q <= in_i;
                    cnt_q  <= TIMER_ZERO;
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
        end else begin
            cnt_q <= TIMER_ZERO;
        end
    end

    // zero settings bypass the counting so the path is unchanged
    always_comb begin
        if (in_i && pickup_i == TIMER_ZERO)
            out_o = 1'b1;
        else if (!in_i && dropout_i == TIMER_ZERO)
            out_o = 1'b0;
        else
            out_o = held_q;
    end

    a_pickup_waits_tick: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        ($rose(held_q) && $past(pickup_i) != TIMER_ZERO) |-> $past(tick_i))
        else $error("pickup completed without a tick");
endmodule
`default_nettype wire

// ===== design/sdze_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1 - step distance zone trips always run, whatever scheme is selected
// RULE2 - three delayed zones (two to four) beside instantaneous zone one
// RULE3 - per-zone phase and ground enables; disabled group never trips
// RULE4 - zones two to four have separate phase and ground delay timers
// RULE5 - zone four direction selectable forward or reverse
// RULE6 - zone one ground uses mho or reactance functions, selectable
// RULE7 - zone two ground uses distance, directional overcurrent, or both
// RULE8 - extension mode without reach reset routes zone two to instantaneous path
// RULE9 - once reclosing starts, true zone one returns until recloser resets
// RULE10 - internal recloser flag drives reach select; contact input then ignored
// RULE11 - flag sets at recloser initiate, clears only at recloser reset state
// RULE12 - in lockout flag holds until manual close then reset state
// RULE13 - reach reset output closed exactly while the flag is set; code registers it, so it follows the flag one clock late
// RULE14 - without internal recloser, external contact arrives on contact input three
// RULE15 - contact input stretched by settable dropout; zero passes unchanged
// RULE16 - momentary external contacts need dropout equal to recloser reclaim time
// RULE17 - every trip output gated by the fault detector
// RULE18 - delayed trip only after function held for the full pickup time; code counts free-running ms ticks, so hold may be up to 1 ms short
module sdze_top
    import sdze_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // measuring function outputs, three per group
    input  wire logic [2:0]               z1_phase_i,
    input  wire logic [2:0]               z1_gnd_mho_i,
    input  wire logic [2:0]               z1_gnd_react_i,
    input  wire logic [2:0]               z2_phase_i,
    input  wire logic [2:0]               z2_gnd_i,
    input  wire logic                     ground_trip_overcurrent_i,
    input  wire logic                     negseq_trip_direction_i,
    input  wire logic                     ground_block_overcurrent_i,
    input  wire logic                     negseq_block_direction_i,
    input  wire logic [2:0]               z3_phase_i,
    input  wire logic [2:0]               z3_gnd_i,
    input  wire logic [2:0]               z4_phase_fwd_i,
    input  wire logic [2:0]               z4_phase_rev_i,
    input  wire logic [2:0]               z4_gnd_fwd_i,
    input  wire logic [2:0]               z4_gnd_rev_i,
    input  wire logic                     fault_detector_i,
    // settings
    input  wire logic [3:0]               phase_enable_i,
    input  wire logic [3:0]               gnd_enable_i,
    input  wire logic                     z1_gnd_select_i,
    input  wire sdze_z2g_mode_type        z2_gnd_mode_i,
    input  wire logic                     z4_direction_i,
    input  wire logic [3*TIMER_W-1:0]     phase_delay_i,
    input  wire logic [3*TIMER_W-1:0]     gnd_delay_i,
    input  wire logic                     extension_enable_i,
    input  wire logic                     internal_recloser_i,
    input  wire logic [TIMER_W-1:0]       stretch_dropout_i,
    // recloser events (same clock)
    input  wire logic                     recloser_initiate_i,
    input  wire logic                     recloser_reset_state_i,
    input  wire logic                     recloser_lockout_i,
    input  wire logic                     manual_close_i,
    // external contact (pin)
    input  wire logic                     contact_input_three_i,
    // outputs
    output logic                          trip_o,
    output logic [3:0]                    zone_trip_o,
    output logic                          reach_reset_output_o,
    output logic                          extension_active_o
);
    logic [1:0]        contact_sync_q;
    logic [17:0]       tick_cnt_q;
    logic              tick_q;
    sdze_rr_state_type rr_state_q;
    logic              manual_seen_q;
    logic              rr_flag;
    logic              ext_stretched;
    logic              reach_reset;
    logic              z1_gnd_sel;
    logic              z2_gnd_dist;
    logic              z2_gnd_dir;
    logic              z2_gnd_all;
    logic [2:0]        z4_phase_sel;
    logic [2:0]        z4_gnd_sel;
    logic [3:0]        phase_raw;
    logic [3:0]        gnd_raw;
    logic [2:0]        phase_delayed;
    logic [2:0]        gnd_delayed;
    logic              z1_true;
    logic              z2_inst;
    logic              zone_trip_selector;
    logic [3:0]        zone_d;
    logic [3:0]        zone_q;
    logic              trip_q;
    logic              rr_out_q;
    logic              ext_act_q;

    // pin input passes two flops before use
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            contact_sync_q <= 2'b00;
        else
            contact_sync_q <= {contact_sync_q[0], contact_input_three_i};
    end

    // millisecond tick shared by all timers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= 18'h0_0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYCLES - 18'h0_0001) begin
            tick_cnt_q <= 18'h0_0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 18'h0_0001;
            tick_q     <= 1'b0;
        end
    end

    // reach-reset flag of the internal recloser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rr_state_q    <= SDZE_RR_IDLE;
            manual_seen_q <= 1'b0;
        end else begin
            case (rr_state_q)
                SDZE_RR_IDLE: begin
                    manual_seen_q <= 1'b0;
                    if (recloser_initiate_i)
                        rr_state_q <= SDZE_RR_SET; // RULE11
                end
                SDZE_RR_SET: begin
                    // initiate wins over a reset in the same cycle
                    if (recloser_lockout_i)
                        rr_state_q <= SDZE_RR_LOCKOUT; // RULE12
                    else if (recloser_reset_state_i && !recloser_initiate_i)
                        rr_state_q <= SDZE_RR_IDLE; // RULE11
                end
                SDZE_RR_LOCKOUT: begin
                    if (manual_close_i)
                        manual_seen_q <= 1'b1;
                    // the reset state only counts once a manual close has already been seen
                    if (manual_seen_q && recloser_reset_state_i && !recloser_lockout_i)
                        rr_state_q <= SDZE_RR_IDLE; // RULE12
                end
                default: rr_state_q <= SDZE_RR_IDLE;
            endcase
        end
    end

    assign rr_flag = (rr_state_q != SDZE_RR_IDLE);

    // external contact stretch; only the dropout is timed
    sdze_timer u_recloser_contact_stretch_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_q),
        .in_i      (contact_sync_q[1]),
        .pickup_i  (TIMER_ZERO),
        .dropout_i (stretch_dropout_i),
        .out_o     (ext_stretched)
    ); // RULE15 RULE14 RULE16

    // reach_select_gate: internal flag or stretched contact
    assign reach_reset = internal_recloser_i ? rr_flag : ext_stretched; // RULE10

    // ground element selection
    assign z1_gnd_sel  = (z1_gnd_select_i == Z1G_REACTANCE) ? |z1_gnd_react_i : |z1_gnd_mho_i; // RULE6
    assign z2_gnd_dist = |z2_gnd_i;
    // directional overcurrent trips on trip elements unless block elements see reverse
    assign z2_gnd_dir  = ground_trip_overcurrent_i && negseq_trip_direction_i
                         && !(ground_block_overcurrent_i && negseq_block_direction_i);

    always_comb begin
        case (z2_gnd_mode_i)
            SDZE_Z2G_DISTANCE: z2_gnd_all = z2_gnd_dist; // RULE7
            SDZE_Z2G_DIROC:    z2_gnd_all = z2_gnd_dir; // RULE7
            SDZE_Z2G_BOTH:     z2_gnd_all = z2_gnd_dist || z2_gnd_dir; // RULE7
            default:           z2_gnd_all = 1'b0;
        endcase
    end

    assign z4_phase_sel = (z4_direction_i == Z4_REVERSE) ? z4_phase_rev_i : z4_phase_fwd_i; // RULE5
    assign z4_gnd_sel   = (z4_direction_i == Z4_REVERSE) ? z4_gnd_rev_i : z4_gnd_fwd_i; // RULE5

    // enables applied before the timers so a disabled group cannot trip
    assign phase_raw = phase_enable_i & {|z4_phase_sel, |z3_phase_i, |z2_phase_i, |z1_phase_i}; // RULE3
    assign gnd_raw   = gnd_enable_i & {|z4_gnd_sel, |z3_gnd_i, z2_gnd_all, z1_gnd_sel}; // RULE3

    // two independent timers for each delayed zone
    genvar gz;
    generate
        for (gz = 0; gz < NUM_DELAYED_ZONES; gz++) begin : g_zone
            sdze_timer u_phase_timer (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .tick_i    (tick_q),
                .in_i      (phase_raw[gz+1]),
                .pickup_i  (phase_delay_i[gz*TIMER_W +: TIMER_W]),
                .dropout_i (TIMER_ZERO),
                .out_o     (phase_delayed[gz])
            ); // RULE4 RULE18 RULE2
            sdze_timer u_gnd_timer (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .tick_i    (tick_q),
                .in_i      (gnd_raw[gz+1]),
                .pickup_i  (gnd_delay_i[gz*TIMER_W +: TIMER_W]),
                .dropout_i (TIMER_ZERO),
                .out_o     (gnd_delayed[gz])
            ); // RULE4 RULE18 RULE2
        end
    endgenerate

    assign z1_true = phase_raw[0] || gnd_raw[0];
    assign z2_inst = phase_raw[1] || gnd_raw[1];
    // zone_trip_selector: true zone one always trips; with extension enabled, zone two joins it until reach reset rises
    assign zone_trip_selector = z1_true
                                || (extension_enable_i && !reach_reset && z2_inst); // RULE8 RULE9 RULE1

    // step distance paths are never switched off by scheme choice
    assign zone_d = {phase_delayed[2] || gnd_delayed[2],
                     phase_delayed[1] || gnd_delayed[1],
                     phase_delayed[0] || gnd_delayed[0],
                     zone_trip_selector}; // RULE1

    // final_trip_gate: fault detector supervises every trip output
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            zone_q <= 4'h0;
            trip_q <= 1'b0;
        end else begin
            zone_q <= zone_d & {4{fault_detector_i}}; // RULE17
            trip_q <= (|zone_d) && fault_detector_i; // RULE17
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rr_out_q  <= 1'b0;
            ext_act_q <= 1'b0;
        end else begin
            rr_out_q  <= rr_flag; // RULE13
            ext_act_q <= extension_enable_i && !reach_reset;
        end
    end

    assign trip_o               = trip_q;
    assign zone_trip_o          = zone_q;
    assign reach_reset_output_o = rr_out_q;
    assign extension_active_o   = ext_act_q;

    // supervision, flag and selector checks
    a_trip_needs_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        trip_o |-> $past(fault_detector_i))
        else $error("trip without fault detector");
    a_zone_needs_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        (|zone_trip_o) |-> $past(fault_detector_i))
        else $error("zone trip without fault detector");
    a_trip_any_zone: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        trip_o == (|zone_trip_o))
        else $error("trip and zone outputs disagree");
    a_rr_output_follows: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
        ##1 (reach_reset_output_o == $past(rr_state_q != SDZE_RR_IDLE)))
        else $error("reach reset output mismatch");
    a_rr_sets_on_init: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        recloser_initiate_i |=> rr_flag)
        else $error("flag not set on initiate");
    a_rr_clear_on_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        ($past(rr_flag) && !rr_flag) |-> $past(recloser_reset_state_i))
        else $error("flag cleared without reset");
    a_lockout_holds_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        (rr_state_q == SDZE_RR_LOCKOUT && !manual_seen_q) |=> rr_flag)
        else $error("lockout dropped flag");
    a_lockout_exit_manual: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        ($past(rr_state_q) == SDZE_RR_LOCKOUT && !rr_flag) |-> $past(manual_seen_q))
        else $error("lockout left without manual close");
    a_extension_routes_z2: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
        (extension_enable_i && !reach_reset && z2_inst && fault_detector_i) |=> zone_trip_o[0])
        else $error("zone two not instantaneous");
    a_reset_restores_z1: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        (reach_reset && !z1_true) |=> !zone_trip_o[0])
        else $error("zone one not restored");
    a_z1_always_trips: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        (z1_true && fault_detector_i) |=> zone_trip_o[0])
        else $error("zone one trip suppressed");
    a_internal_ignores_contact: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
        internal_recloser_i |-> (reach_reset == rr_flag))
        else $error("contact used with internal recloser");
    a_disabled_no_trip: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        (!phase_enable_i[0] && !gnd_enable_i[0] && !extension_enable_i) |=> !zone_trip_o[0])
        else $error("disabled zone tripped");
    a_delayed_needs_input: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        phase_delayed[0] |-> phase_raw[1])
        else $error("delayed trip without function");
    a_gnd_needs_input: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        gnd_delayed[0] |-> gnd_raw[1])
        else $error("delayed ground trip without function");
    a_stretch_follows_pin: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
        contact_sync_q[1] |-> ext_stretched)
        else $error("contact input not passed");
    a_stretch_zero_drop: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
        (stretch_dropout_i == TIMER_ZERO) |-> (ext_stretched == contact_sync_q[1]))
        else $error("zero dropout changed contact");
    a_dir_oc_blocked: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
        (z2_gnd_mode_i == SDZE_Z2G_DIROC && ground_block_overcurrent_i && negseq_block_direction_i) |-> !z2_gnd_all)
        else $error("blocked directional ground tripped");
endmodule
`default_nettype wire

// ===== verif/sdze_recloser_model.sv
`timescale 1ns/1ps
`default_nettype none
// external recloser: each breaker trip starts a step, signalled by a short contact closure
module sdze_recloser_model
(
    input  wire logic clk_i,
    input  wire logic en_i,
    input  wire logic trip_i,
    output logic      contact_o
);
    logic        trip_q;
    int unsigned cnt_q;
    initial begin
        trip_q    = 1'b0;
        cnt_q     = 0;
        contact_o = 1'b0;
    end
    always @(posedge clk_i) begin
        trip_q <= trip_i;
        if (en_i && trip_i && !trip_q) begin
            cnt_q <= 1;
        end else if (cnt_q != 0) begin
            cnt_q <= (cnt_q == 30) ? 0 : cnt_q + 1;
        end
        // momentary only, open contact reads low; the relay stretch must cover reclaim
        contact_o <= (cnt_q >= 20);
    end
endmodule
`default_nettype wire

// ===== verif/tb_sdze_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdze_top;
    import sdze_pkg::*;
    logic               clk_i, rst_i, fault, z1sel, z4dir, ext_en, int_rc, model_en, contact;
    logic [2:0]         z1p, z1m, z1r, z2p, z2g, z3p, z3g, z4pf, z4pr, z4gf, z4gr;
    logic               oc_t, dir_t, oc_b, dir_b, rc_init, rc_rst, rc_lock, man_cl;
    logic [3:0]         pen, gen, ztrip;
    sdze_z2g_mode_type  z2mode;
    logic [47:0]        pdly, gdly;
    logic [15:0]        drop;
    logic               trip, rr_out, ext_act;
    int                 errors, num_checks;
    // mode, trip_oc trip_dir block_oc block_dir, ground distance, expected zone two trip
    localparam logic [7:0] TBL [8] = '{8'b00_1100_0_0, 8'b00_0000_1_1, 8'b01_1100_0_1, 8'b01_1111_0_0,
                                       8'b01_0000_1_0, 8'b10_1110_0_1, 8'b10_0000_1_1, 8'b11_1100_1_0};
    sdze_top u_sdze_top (.clk_i(clk_i), .rst_i(rst_i), .z1_phase_i(z1p), .z1_gnd_mho_i(z1m),
        .z1_gnd_react_i(z1r), .z2_phase_i(z2p), .z2_gnd_i(z2g), .ground_trip_overcurrent_i(oc_t),
        .negseq_trip_direction_i(dir_t), .ground_block_overcurrent_i(oc_b), .negseq_block_direction_i(dir_b),
        .z3_phase_i(z3p), .z3_gnd_i(z3g), .z4_phase_fwd_i(z4pf), .z4_phase_rev_i(z4pr), .z4_gnd_fwd_i(z4gf),
        .z4_gnd_rev_i(z4gr), .fault_detector_i(fault), .phase_enable_i(pen), .gnd_enable_i(gen),
        .z1_gnd_select_i(z1sel), .z2_gnd_mode_i(z2mode), .z4_direction_i(z4dir), .phase_delay_i(pdly),
        .gnd_delay_i(gdly), .extension_enable_i(ext_en), .internal_recloser_i(int_rc),
        .stretch_dropout_i(drop), .recloser_initiate_i(rc_init), .recloser_reset_state_i(rc_rst),
        .recloser_lockout_i(rc_lock), .manual_close_i(man_cl), .contact_input_three_i(contact),
        .trip_o(trip), .zone_trip_o(ztrip), .reach_reset_output_o(rr_out), .extension_active_o(ext_act));
    sdze_recloser_model u_sdze_recloser_model (.clk_i(clk_i), .en_i(model_en), .trip_i(trip), .contact_o(contact));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // 0 initiate, 1 reset state, 2 manual close
    task automatic pulse(input int sel);
        @(posedge clk_i);
        case (sel)
            0: rc_init <= 1'b1;
            1: rc_rst <= 1'b1;
            default: man_cl <= 1'b1;
        endcase
        @(posedge clk_i);
        {rc_init, rc_rst, man_cl} <= 3'b000;
        cyc(3);
    endtask
    // bounded wait on the far-side contact
    task automatic wait_contact(input logic lvl);
        int n;
        n = 0;
        while (contact !== lvl && n < 200) begin
            cyc(1);
            n++;
        end
        chk({3'b000, contact}, {3'b000, lvl});
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        final_report();
    end
    initial begin
        errors = 0;
        num_checks = 0;
        rst_i = 1'b1;
        {fault, z1sel, z4dir, ext_en, int_rc, model_en, oc_t, dir_t, oc_b, dir_b} = '0;
        {z1p, z1m, z1r, z2p, z2g, z3p, z3g, z4pf, z4pr, z4gf, z4gr} = '0;
        {rc_init, rc_rst, rc_lock, man_cl, pdly, gdly, drop} = '0;
        pen = 4'hf;
        gen = 4'hf;
        z2mode = SDZE_Z2G_DISTANCE;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc(2);
        chk({trip, rr_out, ztrip[1:0]}, 4'h0);
        @(posedge clk_i);
        z1p <= 3'b001;
        fault <= 1'b1;
        cyc(3);
        chk({trip, ztrip[2:0]}, 4'h9);
        @(posedge clk_i);
        fault <= 1'b0;
        cyc(3);
        chk({trip, ztrip[2:0]}, 4'h0);
        @(posedge clk_i);
        {fault, pen, gen, z1m} <= {1'b1, 4'he, 4'he, 3'b001};
        cyc(3);
        chk(ztrip, 4'h0);
        @(posedge clk_i);
        {pen, gen, z1p, z1m, z1r, z1sel} <= {4'hf, 4'hf, 3'b000, 3'b000, 3'b010, Z1G_MHO};
        cyc(3);
        chk(ztrip, 4'h0);
        @(posedge clk_i);
        z1sel <= Z1G_REACTANCE;
        cyc(3);
        chk(ztrip, 4'h1);
        @(posedge clk_i);
        gen <= 4'he;
        cyc(3);
        chk(ztrip, 4'h0);
        @(posedge clk_i);
        {gen, z1r, z1m, z1sel} <= {4'hf, 3'b000, 3'b100, Z1G_MHO};
        cyc(3);
        chk(ztrip, 4'h1);
        @(posedge clk_i);
        z1m <= 3'b000;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            z2mode <= sdze_z2g_mode_type'(TBL[i][7:6]);
            {oc_t, dir_t, oc_b, dir_b} <= TBL[i][5:2];
            z2g <= {2'b00, TBL[i][1]};
            cyc(4);
            chk(ztrip, {2'b00, TBL[i][0], 1'b0});
        end
        @(posedge clk_i);
        {oc_t, dir_t, oc_b, dir_b, z2g, z4pr, z4dir} <= {4'h0, 3'b000, 3'b001, Z4_FORWARD};
        cyc(4);
        chk(ztrip, 4'h0);
        @(posedge clk_i);
        z4dir <= Z4_REVERSE;
        cyc(4);
        chk(ztrip, 4'h8);
        @(posedge clk_i);
        {z4pr, z3p, z3g, gdly} <= {3'b000, 3'b001, 3'b001, 48'h0000_0002_0000};
        cyc(4);
        chk(ztrip, 4'h4);
        @(posedge clk_i);
        z3p <= 3'b000;
        cyc(1000);
        chk(ztrip, 4'h0);
        // zone two delayed 5 ms so only the extension path can trip quickly
        @(posedge clk_i);
        {z3g, gdly, pdly, ext_en, int_rc, model_en, z2p} <= {3'b000, 48'h0, 48'h0005, 3'b111, 3'b010};
        cyc(3);
        chk({ext_act, ztrip[2:0]}, 4'h9);
        wait_contact(1'b1);
        cyc(4);
        chk(ztrip, 4'h1);
        pulse(0);
        chk({rr_out, ztrip[2:0]}, 4'h8);
        pulse(1);
        chk({rr_out, ztrip[2:0]}, 4'h1);
        pulse(0);
        @(posedge clk_i);
        rc_lock <= 1'b1;
        pulse(1);
        chk({3'b000, rr_out}, 4'h1);
        @(posedge clk_i);
        rc_lock <= 1'b0;
        pulse(1);
        chk({3'b000, rr_out}, 4'h1);
        pulse(2);
        pulse(1);
        chk({rr_out, ztrip[2:0]}, 4'h1);
        @(posedge clk_i);
        {int_rc, z2p} <= 4'h0;
        cyc(3);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            z2p <= 3'b010;
            cyc(3);
            chk(ztrip, 4'h1);
            wait_contact(1'b1);
            cyc(4);
            chk(ztrip, 4'h0);
            wait_contact(1'b0);
            cyc(k == 0 ? 4 : 100);
            chk(ztrip, k == 0 ? 4'h1 : 4'h0);
            @(posedge clk_i);
            {z2p, drop} <= {3'b000, 16'h0002};
            cyc(3);
        end
        final_report();
    end
endmodule
`default_nettype wire
